// file: emrc_top.v
// Purpose: Run control of an in-circuit emulator for an 8-bit microcontroller.
// Assumes: One 100 MHz clock; pins pass a three-stage synchroniser.
// Notes:   Registers sit on AHB-Lite with zero wait states.
// Notes on behaviour
// - The processor clock is picked by a panel switch from internal, external logic clock or emulation board clock.
// - The internal clock is 10 MHz at 50% duty by default, and a jumper selects 2.5 MHz or 5 MHz instead.
// - The panel reset resets the whole emulator including the emulation processor.
// - The target reset reaches the processor only in emulation state and is ignored in monitor state.
// - In monitor state a register-reset command resets the processor and clears all its registers.
// - In in-circuit mode 1 a setting enables or disables forwarding of the target reset.
// - The monitor switch during emulation breaks execution and hands control to the monitor.
// - While the monitor lamp is lit, external and timer interrupts are blocked.
// - The timer keeps counting in monitor state, at a lower effective rate.
// - Target reset, interrupt and single-step are ignored in mode 0, maskable in mode 1, live in mode 2; external-access is live in mode 2 only.
// - In monitor state the address latch enable toggles irregularly and is no periodic clock.
// - The emulation processor has 256 bytes of internal data memory.
// - The bus port and port two are simulated and their output depends on the emulation-select switch.
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
`include "emrc_defs.vh"
module emrc_top
(
  input  wire        clk_i,
  input  wire        arst_n_i,
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  input  wire [1:0]  clock_select_i,
  input  wire [1:0]  int_clk_jumper_i,
  input  wire        ext_clk_i,
  input  wire        logic_clock_input_i,
  input  wire        inverted_clock_input_i,
  input  wire        panel_reset_n_i,
  input  wire        monitor_switch_n_i,
  input  wire [1:0]  incircuit_mode_i,
  input  wire        emul_select_i,
  input  wire        target_reset_n_i,
  input  wire        target_int_n_i,
  input  wire        target_step_i,
  input  wire        external_access_input_i,
  input  wire        cpu_ale_i,
  input  wire        cpu_timer_ovf_i,
  input  wire [7:0]  cpu_bus_i,
  input  wire [3:0]  cpu_p2_i,
  output reg         cpu_clk_o,
  output reg         cpu_reset_o,
  output reg         cpu_int_o,
  output reg         cpu_timer_int_o,
  output reg         cpu_timer_tick_o,
  output reg         cpu_step_o,
  output reg         cpu_ea_o,
  output reg         monitor_lamp_o,
  output reg         ale_o,
  output reg  [7:0]  bus_port_o,
  output reg         bus_port_oe_o,
  output reg  [3:0]  port_two_low_nibble_o,
  output reg         emu_reset_n_o
);
  localparam ST_EMUL = 2'b01;
  localparam ST_MON  = 2'b10;

  // Three-stage synchronisers for all asynchronous inputs.
  localparam NSYNC = 15;
  wire [NSYNC-1:0] async_w = {clock_select_i, int_clk_jumper_i, ext_clk_i, logic_clock_input_i,
                              inverted_clock_input_i, panel_reset_n_i, monitor_switch_n_i, incircuit_mode_i,
                              emul_select_i, target_reset_n_i, target_int_n_i, target_step_i};
  reg  [NSYNC-1:0] s1_r;
  reg  [NSYNC-1:0] s2_r;
  reg  [NSYNC-1:0] s3_r;
  reg  [NSYNC-1:0] in_r;
  reg              ea_s1_r;
  reg              ea_s2_r;
  reg              ea_s3_r;
  reg              ea_r;
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1)
    begin : g_sync
      always @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
          s3_r[g] <= 1'b0;
          in_r[g] <= 1'b0;
        end
        else
        begin
          s1_r[g] <= async_w[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g])
            in_r[g] <= s3_r[g];
        end
      end
    end
  endgenerate

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ea_s1_r <= 1'b0;
      ea_s2_r <= 1'b0;
      ea_s3_r <= 1'b0;
      ea_r    <= 1'b0;
    end
    else
    begin
      ea_s1_r <= external_access_input_i;
      ea_s2_r <= ea_s1_r;
      ea_s3_r <= ea_s2_r;
      if (ea_s2_r == ea_s3_r)
        ea_r <= ea_s3_r;
    end
  end

  wire [1:0] clk_sel_w   = in_r[14:13];
  wire [1:0] jumper_w    = in_r[12:11];
  wire       ext_clk_w   = in_r[10];
  wire       brd_clk_w   = in_r[9] & ~in_r[8];
  wire       panel_rst_w = ~in_r[7];
  wire       mon_sw_w    = ~in_r[6];
  wire [1:0] mode_w      = in_r[5:4];
  wire       emsel_w     = in_r[3];
  wire       tgt_rst_w   = ~in_r[2];
  wire       tgt_int_w   = ~in_r[1];
  wire       tgt_step_w  = in_r[0];

  // Registers: control, pin mask, command.
  reg  [7:0] ctrl_r;
  reg  [3:0] mask_r;
  reg  [1:0] state_r;
  reg  [3:0] regrst_cnt_r;
  reg        mon_sw_d_r;
  reg        break_cmd_r;
  reg        go_cmd_r;
  reg        regrst_cmd_r;
  wire       tgt_rst_en_w = ctrl_r[0];
  wire       in_mon_w     = state_r[1];

  // AHB-Lite slave, zero wait states, always OKAY.
  reg        dph_r;
  reg        dph_wr_r;
  reg  [7:0] dph_addr_r;
  wire       aph_w = hsel_i & hready_i & htrans_i[1];
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dph_r      <= 1'b0;
      dph_wr_r   <= 1'b0;
      dph_addr_r <= 8'h00;
    end
    else if (hready_i)
    begin
      dph_r      <= aph_w;
      dph_wr_r   <= hwrite_i;
      dph_addr_r <= haddr_i[7:0];
    end
  end

  wire wr_w = dph_r & dph_wr_r;
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_r       <= `EMRC_CTRL_RST;
      mask_r       <= `EMRC_MASK_RST;
      break_cmd_r  <= 1'b0;
      go_cmd_r     <= 1'b0;
      regrst_cmd_r <= 1'b0;
    end
    else
    begin
      break_cmd_r  <= 1'b0;
      go_cmd_r     <= 1'b0;
      regrst_cmd_r <= 1'b0;
      if (panel_rst_w)
      begin
        ctrl_r <= `EMRC_CTRL_RST;
        mask_r <= `EMRC_MASK_RST;
      end
      else if (wr_w && dph_addr_r == `EMRC_OFF_CTRL)
        ctrl_r <= hwdata_i[7:0];
      else if (wr_w && dph_addr_r == `EMRC_OFF_MASK)
        mask_r <= hwdata_i[3:0];
      else if (wr_w && dph_addr_r == `EMRC_OFF_CMD)
      begin
        go_cmd_r     <= hwdata_i[0];
        break_cmd_r  <= hwdata_i[1];
        regrst_cmd_r <= hwdata_i[2] & in_mon_w;
      end
    end
  end

  wire [31:0] stat_w = {16'h0000, 4'h0, ctrl_r[7:4], emsel_w, mode_w, clk_sel_w,
                        cpu_reset_o, state_r};
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (aph_w && !hwrite_i)
      begin
        if (haddr_i[7:0] == `EMRC_OFF_CTRL)
          hrdata_o <= {24'h000000, ctrl_r};
        else if (haddr_i[7:0] == `EMRC_OFF_MASK)
          hrdata_o <= {28'h0000000, mask_r};
        else if (haddr_i[7:0] == `EMRC_OFF_STAT)
          hrdata_o <= stat_w;
        else if (haddr_i[7:0] == `EMRC_OFF_PORT)
          hrdata_o <= {20'h00000, port_two_low_nibble_o, bus_port_o};
        else if (haddr_i[7:0] == `EMRC_OFF_ID)
          hrdata_o <= `EMRC_ID_VALUE;
        else
          hrdata_o <= 32'h0000_0000;
      end
    end
  end

  // Run state: monitor switch and break command enter monitor; go leaves it.
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_r    <= ST_MON;
      mon_sw_d_r <= 1'b0;
    end
    else
    begin
      mon_sw_d_r <= mon_sw_w;
      if (panel_rst_w)
        state_r <= ST_MON;
      else
        case (state_r)
          ST_EMUL:
            if ((mon_sw_w && !mon_sw_d_r) || break_cmd_r)
              state_r <= ST_MON;
          ST_MON:
            if (go_cmd_r)
              state_r <= ST_EMUL;
          default:
            state_r <= ST_MON;
        endcase
    end
  end

  // Register-reset holds the processor in reset for a few cycles.
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      regrst_cnt_r <= 4'h0;
    else if (regrst_cmd_r)
      regrst_cnt_r <= `EMRC_REGRST_CYC;
    else if (regrst_cnt_r != 4'h0)
      regrst_cnt_r <= regrst_cnt_r - 4'h1;
  end

  // Mode gating: the mask bit set means that input is blocked in mode 1.
  wire m1_w = (mode_w == 2'd1);
  wire m2_w = (mode_w == 2'd2);
  wire rst_ok_w  = (m2_w | (m1_w & tgt_rst_en_w & ~mask_r[0])) & ~in_mon_w;
  wire int_ok_w  = (m2_w | (m1_w & ~mask_r[1])) & ~in_mon_w;
  wire step_ok_w = m2_w | (m1_w & ~mask_r[2]);
  wire ea_ok_w   = m2_w & ea_r;

  // Internal clock divider; half periods in system cycles.
  reg  [4:0] div_cnt_r;
  reg        int_clk_r;
  reg  [4:0] half_w;
  always @*
  begin
    case (jumper_w)
      2'd1:    half_w = `EMRC_INT_DIV_5M;
      2'd2:    half_w = `EMRC_INT_DIV_2M5;
      default: half_w = `EMRC_INT_DIV_10M;
    endcase
  end
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      div_cnt_r <= 5'h00;
      int_clk_r <= 1'b0;
    end
    else if (div_cnt_r >= half_w - 5'h01)
    begin
      div_cnt_r <= 5'h00;
      int_clk_r <= ~int_clk_r;
    end
    else
      div_cnt_r <= div_cnt_r + 5'h01;
  end

  // Timer ticks are thinned in monitor state.
  reg  [3:0] tmr_div_r;
  reg        tmr_ovf_d_r;
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tmr_div_r <= 4'h0;
      tmr_ovf_d_r <= 1'b0;
    end
    else
    begin
      tmr_ovf_d_r <= cpu_timer_ovf_i;
      tmr_div_r <= (tmr_div_r >= `EMRC_MON_TMR_DIV - 4'h1) ? 4'h0 : tmr_div_r + 4'h1;
    end
  end

  // All gated outputs update together on one edge.
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cpu_clk_o             <= 1'b0;
      cpu_reset_o           <= 1'b1;
      emu_reset_n_o         <= 1'b0;
      cpu_int_o             <= 1'b0;
      cpu_timer_int_o       <= 1'b0;
      cpu_timer_tick_o      <= 1'b0;
      cpu_step_o            <= 1'b0;
      cpu_ea_o              <= 1'b0;
      monitor_lamp_o        <= 1'b1;
      ale_o                 <= 1'b0;
      bus_port_o            <= 8'h00;
      bus_port_oe_o         <= 1'b0;
      port_two_low_nibble_o <= 4'h0;
    end
    else
    begin
      case (clk_sel_w)
        `EMRC_CLK_EXT:   cpu_clk_o <= ext_clk_w;
        `EMRC_CLK_BOARD: cpu_clk_o <= brd_clk_w;
        default:         cpu_clk_o <= int_clk_r;
      endcase
      cpu_reset_o      <= panel_rst_w | (regrst_cnt_r != 4'h0) | (rst_ok_w & tgt_rst_w);
      emu_reset_n_o    <= ~panel_rst_w;
      cpu_int_o        <= int_ok_w & tgt_int_w;
      cpu_timer_int_o  <= cpu_timer_ovf_i & ~tmr_ovf_d_r & ~in_mon_w;
      cpu_timer_tick_o <= ~in_mon_w | (tmr_div_r == 4'h0);
      cpu_step_o       <= step_ok_w & tgt_step_w;
      cpu_ea_o         <= ea_ok_w;
      monitor_lamp_o   <= in_mon_w;
      // Monitor firmware drives the processor bus freely, so ALE is not a clock then.
      ale_o            <= cpu_ale_i;
      // Simulated ports: with emulation-select on, internal accesses stay off the target.
      bus_port_o            <= cpu_bus_i;
      bus_port_oe_o         <= ~in_mon_w & ~emsel_w;
      port_two_low_nibble_o <= (in_mon_w & emsel_w) ? 4'hf : cpu_p2_i;
    end
  end

  // The emulation processor itself carries 256 data bytes; this block only passes its pins.
  localparam DMEM_BYTES = `EMRC_DMEM_BYTES;
endmodule // emrc_top

// file: emrc_defs.vh
// Purpose: Constants for the emulator run-control block.
// Assumes: 100 MHz system clock, AHB-Lite register access.
// Notes:   Offsets are byte addresses of 32-bit words.
`ifndef EMRC_DEFS_VH
`define EMRC_DEFS_VH
`define EMRC_OFF_CTRL        8'h00
`define EMRC_OFF_MASK        8'h04
`define EMRC_OFF_STAT        8'h08
`define EMRC_OFF_CMD         8'h0c
`define EMRC_OFF_PORT        8'h10
`define EMRC_OFF_ID          8'h14
`define EMRC_CTRL_RST        8'h00
`define EMRC_MASK_RST        4'h0
`define EMRC_ID_VALUE        32'h0000_5a01  // Arbitrary value, it names no part.
`define EMRC_CLK_INT         2'd0
`define EMRC_CLK_EXT         2'd1
`define EMRC_CLK_BOARD       2'd2
`define EMRC_SYS_MHZ         100
`define EMRC_INT_DIV_10M     5'd5
`define EMRC_INT_DIV_5M      5'd10
`define EMRC_INT_DIV_2M5     5'd20
`define EMRC_REGRST_CYC      4'd8
`define EMRC_MON_TMR_DIV     4'd4
`define EMRC_DMEM_BYTES      256
`endif

// file: emrc_tgt_model.sv
// Purpose: Target board pins as seen by the run control.
// Assumes: The bench raises pin requests and holds them.
// Notes:   The board clock runs free, as a real target oscillator would.
`timescale 1ns/10ps
module emrc_tgt_model
(
  input  logic       clk_i,
  input  logic [3:0] req_i,
  output logic       rst_n_o,
  output logic       int_n_o,
  output logic       step_o,
  output logic       ea_o,
  output logic       clk_o
);
  logic [1:0] div_r = 2'h0;
  // Requests are active high; reset and interrupt pins are active low.
  always @(posedge clk_i)
  begin
    div_r <= div_r + 2'h1;
    {ea_o, step_o, int_n_o, rst_n_o} <= req_i ^ 4'b0011;
  end
  assign clk_o = div_r[1];
endmodule // emrc_tgt_model

// file: emrc_checker.sv
// Purpose: Port checks of the run control.
// Assumes: Mode, clock select and jumper stay put while watched.
// Notes:   Pin gating is checked against the lamp, not the slow inputs.
`timescale 1ns/10ps
`include "emrc_defs.vh"
module emrc_checker
(
  input wire        clk_i,
  input wire        arst_n_i,
  input wire        hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0]  htrans_i,
  input wire        hwrite_i,
  input wire        hready_i,
  input wire [31:0] hrdata_o,
  input wire        hreadyout_o,
  input wire        hresp_o,
  input wire [1:0]  clock_select_i,
  input wire [1:0]  int_clk_jumper_i,
  input wire        panel_reset_n_i,
  input wire        cpu_clk_o,
  input wire        cpu_int_o,
  input wire        cpu_timer_int_o,
  input wire        monitor_lamp_o,
  input wire        bus_port_oe_o,
  input wire        emu_reset_n_o
);
  // Cycles since clock select or jumper last moved; the divider needs time to settle after a change.
  logic [3:0] calm_r;
  logic [3:0] sel_d_r;
  always @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      calm_r  <= 4'h0;
      sel_d_r <= 4'h0;
    end
    else
    begin
      sel_d_r <= {clock_select_i, int_clk_jumper_i};
      if (sel_d_r != {clock_select_i, int_clk_jumper_i})
        calm_r <= 4'h0;
      else if (calm_r != 4'hf)
        calm_r <= calm_r + 4'h1;
    end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_id_take;
    hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i == 32'h14;
  endsequence
  sequence s_high_half;
    cpu_clk_o [*5] ##1 !cpu_clk_o;
  endsequence
  a_bus_ready: assert property (hreadyout_o) else $error("hreadyout dropped");
  a_resp_okay: assert property (!hresp_o) else $error("error response seen");
  a_id_read: assert property (s_id_take |=> hrdata_o == `EMRC_ID_VALUE) else $error("id read wrong");
  a_int_blocked: assert property (monitor_lamp_o |-> !cpu_int_o) else $error("int in monitor");
  a_tmr_blocked: assert property (monitor_lamp_o |-> !cpu_timer_int_o) else $error("timer int in monitor");
  a_tmr_pulse: assert property (cpu_timer_int_o |=> !cpu_timer_int_o) else $error("timer int too long");
  a_clk_half: assert property ($rose(cpu_clk_o) && clock_select_i == 2'd0 && int_clk_jumper_i == 2'd0 && calm_r == 4'hf
    |-> s_high_half) else $error("internal clock half period wrong");
  a_panel_rst: assert property ((!panel_reset_n_i) [*6] |-> !emu_reset_n_o) else $error("panel reset lost");
  a_port_mon: assert property (bus_port_oe_o |-> !monitor_lamp_o) else $error("bus port driven in monitor");
endmodule // emrc_checker

// file: tb_top.sv
// Purpose: Self-checking bench of the run control.
// Assumes: Zero wait state bus; gated pins settle within ten cycles.
// Notes:   Emulation cpu pins are random each cycle from a fixed seed.
`timescale 1ns/10ps
`include "emrc_defs.vh"
module tb_top;
  logic clk_i = 1'b0, arst_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, emul_select_i = 1'b0;
  logic panel_reset_n_i = 1'b1, monitor_switch_n_i = 1'b1, inverted_clock_input_i = 1'b0;
  logic cpu_ale_i = 1'b0, cpu_timer_ovf_i = 1'b0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, rd, hrdata_o;
  logic [1:0] htrans_i = 2'h0, clock_select_i = 2'h0, int_clk_jumper_i = 2'h0, incircuit_mode_i = 2'h2;
  logic [2:0] hsize_i = 3'h2;
  logic [7:0] cpu_bus_i = 8'h0, bus_port_o;
  logic [3:0] cpu_p2_i = 4'h0, req = 4'h0, nib, port_two_low_nibble_o;
  wire hready_i, logic_clock_input_i, ext_clk_i, target_reset_n_i, target_int_n_i;
  wire target_step_i, external_access_input_i;
  logic hreadyout_o, hresp_o, cpu_clk_o, cpu_reset_o, cpu_int_o, cpu_timer_int_o, cpu_timer_tick_o;
  logic cpu_step_o, cpu_ea_o, monitor_lamp_o, ale_o, bus_port_oe_o, emu_reset_n_o;
  integer failures = 0, checks = 0, cyc = 0, seed = 32'hb3c9, i, n, m;
  logic [13:0] pv = 14'h0;
  logic ovf_d = 1'b0;
  logic [1:0] live = 2'b00;
  assign hready_i = hreadyout_o;
  assign logic_clock_input_i = ext_clk_i;
  emrc_top dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .clock_select_i(clock_select_i),
    .int_clk_jumper_i(int_clk_jumper_i), .ext_clk_i(ext_clk_i), .logic_clock_input_i(logic_clock_input_i),
    .inverted_clock_input_i(inverted_clock_input_i), .panel_reset_n_i(panel_reset_n_i),
    .monitor_switch_n_i(monitor_switch_n_i), .incircuit_mode_i(incircuit_mode_i),
    .emul_select_i(emul_select_i), .target_reset_n_i(target_reset_n_i), .target_int_n_i(target_int_n_i),
    .target_step_i(target_step_i), .external_access_input_i(external_access_input_i), .cpu_ale_i(cpu_ale_i),
    .cpu_timer_ovf_i(cpu_timer_ovf_i), .cpu_bus_i(cpu_bus_i), .cpu_p2_i(cpu_p2_i), .cpu_clk_o(cpu_clk_o),
    .cpu_reset_o(cpu_reset_o), .cpu_int_o(cpu_int_o), .cpu_timer_int_o(cpu_timer_int_o),
    .cpu_timer_tick_o(cpu_timer_tick_o), .cpu_step_o(cpu_step_o), .cpu_ea_o(cpu_ea_o),
    .monitor_lamp_o(monitor_lamp_o), .ale_o(ale_o), .bus_port_o(bus_port_o), .bus_port_oe_o(bus_port_oe_o),
    .port_two_low_nibble_o(port_two_low_nibble_o), .emu_reset_n_o(emu_reset_n_o));
  emrc_tgt_model tgt_u (.clk_i(clk_i), .req_i(req), .rst_n_o(target_reset_n_i), .int_n_o(target_int_n_i),
    .step_o(target_step_i), .ea_o(external_access_input_i), .clk_o(ext_clk_i));
  always #5 clk_i = ~clk_i;
  // Pass-through pins are checked every cycle, port two and the timer tick only while the lamp is dark, half a cycle after the edge that launches them.
  always @(negedge clk_i)
    if (live[1])
    begin
      chk(ale_o, pv[1]);
      chk(bus_port_o, pv[13:6]);
      chk(cpu_timer_int_o, pv[0] & ~ovf_d & ~monitor_lamp_o);
      if (!monitor_lamp_o)
      begin
        chk(cpu_timer_tick_o, 1'b1);
        chk(port_two_low_nibble_o, pv[5:2]);
      end
    end
  always @(posedge clk_i)
  begin
    {cpu_bus_i, cpu_p2_i, cpu_ale_i, cpu_timer_ovf_i} <= 14'($random(seed));
    pv <= {cpu_bus_i, cpu_p2_i, cpu_ale_i, cpu_timer_ovf_i};
    ovf_d <= pv[0];
    live <= {live[0], arst_n_i};
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      failures = failures + 1;
      give_verdict;
    end
  end
  task give_verdict;
  begin
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    checks = checks + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // Single non-pipelined transfer; read data lands in rd.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
  begin
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= a;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    rd = hrdata_o;
    hsel_i <= 1'b0;
  end
  endtask
  // Pins cross a synchroniser, so each change is given ten cycles.
  task automatic pins(input logic [3:0] r);
  begin
    req <= r;
    repeat (10) @(posedge clk_i);
  end
  endtask
  // Counts rising edges of the processor clock over len sampled steps.
  task automatic rises(input integer len, output integer r);
    logic last;
  begin
    r = 0;
    @(negedge clk_i);
    last = cpu_clk_o;
    repeat (len)
    begin
      @(negedge clk_i);
      r = r + (cpu_clk_o & ~last);
      last = cpu_clk_o;
    end
  end
  endtask
  task automatic clk_case(input logic [1:0] s, input logic [1:0] j, input logic v, input integer e);
    integer r;
  begin
    @(posedge clk_i);
    clock_select_i <= s;
    int_clk_jumper_i <= j;
    inverted_clock_input_i <= v;
    repeat (60) @(posedge clk_i);
    rises(200, r);
    chk(r, e);
  end
  endtask
  function automatic logic [31:0] stat_exp(input logic [3:0] s, input logic [1:0] m, input logic [1:0] st);
    stat_exp = {20'h0, s, emul_select_i, m, 2'h0, 1'b0, st};
  endfunction
  initial
  begin
    repeat (12) @(posedge clk_i);
    chk({monitor_lamp_o, cpu_reset_o, emu_reset_n_o, hreadyout_o}, 4'b1101);
    arst_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    bus(1'b0, `EMRC_OFF_ID, 32'h0);
    chk(rd, `EMRC_ID_VALUE);
    bus(1'b0, 32'h20, 32'h0);
    chk(rd, 32'h0);
    nib = 4'($random(seed));
    bus(1'b1, `EMRC_OFF_CTRL, {24'h0, nib, 4'h1});
    bus(1'b0, `EMRC_OFF_STAT, 32'h0);
    chk(rd, stat_exp(nib, 2'h2, 2'h2));
    pins(4'hf);
    chk({cpu_reset_o, cpu_int_o, cpu_step_o, cpu_ea_o}, 4'b0011);
    pins(4'h0);
    $display("test registers and monitor gating done");
    bus(1'b1, `EMRC_OFF_CMD, 32'h1);
    pins(4'hf);
    chk({monitor_lamp_o, cpu_reset_o, cpu_int_o, cpu_step_o, cpu_ea_o, bus_port_oe_o}, 6'h1f);
    emul_select_i <= 1'b1;
    pins(4'h0);
    chk(bus_port_oe_o, 1'b0);
    for (i = 0; i < 2; i = i + 1)
    begin
      incircuit_mode_i <= i[1:0];
      bus(1'b1, `EMRC_OFF_MASK, 32'h2);
      pins(4'hf);
      chk({cpu_reset_o, cpu_int_o, cpu_step_o, cpu_ea_o}, {i[0], 1'b0, i[0], 1'b0});
      bus(1'b1, `EMRC_OFF_MASK, 32'h0);
      repeat (8) @(posedge clk_i);
      chk(cpu_int_o, i[0]);
      pins(4'h0);
    end
    bus(1'b1, `EMRC_OFF_CTRL, 32'h0);
    pins(4'h1);
    chk(cpu_reset_o, 1'b0);
    $display("test emulation modes done");
    incircuit_mode_i <= 2'h2;
    pins(4'h2);
    chk(cpu_int_o, 1'b1);
    monitor_switch_n_i <= 1'b0;
    pins(4'h2);
    monitor_switch_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk({monitor_lamp_o, cpu_int_o}, 2'b10);
    chk(port_two_low_nibble_o, 4'hf);
    pins(4'h0);
    bus(1'b1, `EMRC_OFF_CMD, 32'h4);
    n = 0;
    m = 0;
    repeat (20)
    begin
      @(posedge clk_i);
      n = n + cpu_reset_o;
      m = m + cpu_timer_tick_o;
    end
    chk(n, 32'd8);
    chk(m, 32'd5);
    bus(1'b1, `EMRC_OFF_MASK, 32'h7);
    bus(1'b1, `EMRC_OFF_CMD, 32'h1);
    repeat (3) @(posedge clk_i);
    chk(monitor_lamp_o, 1'b0);
    bus(1'b1, `EMRC_OFF_CMD, 32'h2);
    repeat (3) @(posedge clk_i);
    chk(monitor_lamp_o, 1'b1);
    bus(1'b1, `EMRC_OFF_CMD, 32'h1);
    repeat (3) @(posedge clk_i);
    panel_reset_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk({emu_reset_n_o, cpu_reset_o}, 2'b01);
    panel_reset_n_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk(monitor_lamp_o, 1'b1);
    bus(1'b0, `EMRC_OFF_MASK, 32'h0);
    chk(rd, {28'h0, `EMRC_MASK_RST});
    $display("test break, register reset and panel reset done");
    clk_case(2'd0, 2'd2, 1'b0, 5);
    clk_case(2'd0, 2'd1, 1'b0, 10);
    clk_case(`EMRC_CLK_EXT, 2'd0, 1'b0, 50);
    clk_case(`EMRC_CLK_BOARD, 2'd0, 1'b0, 50);
    clk_case(`EMRC_CLK_BOARD, 2'd0, 1'b1, 0);
    $display("test clock sources done");
    give_verdict;
  end
endmodule // tb_top
bind emrc_top emrc_checker chk_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .clock_select_i(clock_select_i), .int_clk_jumper_i(int_clk_jumper_i),
  .panel_reset_n_i(panel_reset_n_i), .cpu_clk_o(cpu_clk_o), .cpu_int_o(cpu_int_o),
  .cpu_timer_int_o(cpu_timer_int_o), .monitor_lamp_o(monitor_lamp_o), .bus_port_oe_o(bus_port_oe_o),
  .emu_reset_n_o(emu_reset_n_o));
